// [ecp_pkg.sv]
// Package for the configuration preload loader: word addresses, field
// positions inside the preload words, per-port field layout and defaults.
// Assumes one core clock and a word-read engine in front of the EEPROM.
package ecp_pkg;

    localparam int unsigned ECP_NUM_PORTS = 3;
    localparam int unsigned ECP_WORD_W    = 16;
    localparam int unsigned ECP_ADDR_W    = 8;

    // Preload word addresses, in EEPROM byte address units.
    localparam logic [7:0] ECP_A_SIG   = 8'h00;
    localparam logic [7:0] ECP_A_VID   = 8'h02;
    localparam logic [7:0] ECP_A_DID   = 8'h04;
    localparam logic [7:0] ECP_A_W06   = 8'h06;
    localparam logic [7:0] ECP_A_SSVID = 8'h08;
    localparam logic [7:0] ECP_A_SSID  = 8'h0a;
    localparam logic [7:0] ECP_A_W0C   = 8'h0c;
    localparam logic [7:0] ECP_A_W0E   = 8'h0e;
    localparam logic [7:0] ECP_A_STEP  = 8'h02;

    // Expected signature; the value is arbitrary.
    localparam logic [15:0] ECP_SIG_DEFAULT = 16'h5a3c;

    // Identifier defaults kept when no valid image is found; values are arbitrary.
    localparam logic [15:0] ECP_VID_DEFAULT   = 16'h1234;
    localparam logic [15:0] ECP_DID_DEFAULT   = 16'h0001;
    localparam logic [15:0] ECP_SSVID_DEFAULT = 16'h1234;
    localparam logic [15:0] ECP_SSID_DEFAULT  = 16'h0001;

    // Load strobe indices.
    localparam int unsigned ECP_LD_W06 = 0;
    localparam int unsigned ECP_LD_W0C = 1;
    localparam int unsigned ECP_LD_W0E = 2;
    localparam int unsigned ECP_LD_N   = 3;

    // Field positions in word 06h.
    localparam int unsigned W06_EXT_VC   = 0;
    localparam int unsigned W06_L0S_LO   = 1;
    localparam int unsigned W06_L1_LO    = 4;
    localparam int unsigned W06_NOORD_EG = 8;
    localparam int unsigned W06_NOORD_TG = 9;
    localparam int unsigned W06_SNF      = 10;
    localparam int unsigned W06_CT_LO    = 11;
    localparam int unsigned W06_ARB      = 13;
    localparam int unsigned W06_CRED     = 14;
    localparam int unsigned W06_INTA     = 15;

    // Field positions in word 0Ch.
    localparam int unsigned W0C_MPS_LO = 0;
    localparam int unsigned W0C_ASPM_LO = 2;
    localparam int unsigned W0C_RBER   = 4;
    localparam int unsigned W0C_MSI_DIS = 5;
    localparam int unsigned W0C_PAR_DIS = 6;
    localparam int unsigned W0C_PM_DIS = 7;
    localparam int unsigned W0C_PPNP   = 8;
    localparam int unsigned W0C_LBW    = 9;
    localparam int unsigned W0C_FRZ    = 10;
    localparam int unsigned W0C_SOF    = 11;
    localparam int unsigned W0C_SDN    = 12;
    localparam int unsigned W0C_PMDS   = 13;
    localparam int unsigned W0C_LTR    = 14;
    localparam int unsigned W0C_4KB    = 15;

    // Field positions in word 0Eh.
    localparam int unsigned W0E_LOW_LO  = 0;
    localparam int unsigned W0E_HIGH_LO = 5;
    localparam int unsigned W0E_HALF_LO = 10;
    localparam int unsigned W0E_OBFF    = 15;

    // Per-port fields, grouped by their configuration register.
    typedef struct packed {
        logic       ext_vc_count;                      // 144h bit 0
        logic [2:0] l0s_exit_latency;                  // CCh 14:12
        logic [2:0] l1_exit_latency;                   // CCh 17:15
        logic [1:0] aspm_support;                      // CCh 11:10
        logic       link_bw_notify_cap;                // CCh 21
        logic       surprise_down_cap;                 // CCh 19
        logic       no_order_egress;                   // 74h 5
        logic       no_order_tag;                      // 74h 6
        logic       store_and_forward;                 // 74h 0
        logic [1:0] cut_through_threshold;             // 74h 2:1
        logic       port_arbiter_mode;                 // 74h 3
        logic       credit_update_mode;                // 74h 4
        logic       compliance_parity_dis;             // 74h 15
        logic       intx_pin_request;                  // 3Ch 8
        logic [1:0] max_payload_support;               // C4h 1:0
        logic       role_err_report;                   // C4h 15
        logic       msi_cap_dis;                       // 70h 14
        logic       pm_cap_dis;                        // 70h 13
        logic       posted_pass_nonposted_enable;      // 8Ch 5
        logic       ordering_frozen;                   // 8Ch 6
        logic       tx_frame_start_latency_mode;       // 8Ch 0
        logic       pm_data_select_rw;                 // 8Ch 1
        logic       boundary_4k_check;                 // 8Ch 3
        logic       ltr_cap_en;                        // E4h 12
        logic       obff_cap_en;                       // E4h 18
        logic [4:0] tx_drive_level_low_deemph_margin;  // 94h 4:0
        logic [4:0] tx_drive_level_high_deemph_margin; // 94h 9:5
        logic [4:0] tx_drive_level_half_swing_margin;  // 94h 14:10
    } ecp_port_cfg_t;

    localparam ecp_port_cfg_t ECP_PORT_CFG_DEFAULT = '0;

    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] device_id;
        logic [15:0] subsys_vendor_id;
        logic [15:0] subsys_id;
    } ecp_ids_t;

    localparam ecp_ids_t ECP_IDS_DEFAULT = '{ECP_VID_DEFAULT, ECP_DID_DEFAULT,
                                             ECP_SSVID_DEFAULT, ECP_SSID_DEFAULT};

    // Gray codes along idle, request, wait, next, done.
    typedef enum logic [2:0] {
        ECP_ST_IDLE = 3'h0,
        ECP_ST_REQ  = 3'h1,
        ECP_ST_WAIT = 3'h3,
        ECP_ST_NEXT = 3'h2,
        ECP_ST_DONE = 3'h6
    } ecp_state_t;

endpackage : ecp_pkg

// [ecp_port_map.sv]
// One port's slice of the preloaded configuration fields.
// Assumes load strobes and word come from the loader on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ecp_port_map
    import ecp_pkg::*;
#(
    parameter int unsigned PORT_IDX = 0
)
(
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  nrst_in,
    // Load strobes with the word being applied
    input  wire logic [ECP_LD_N-1:0]   ld_in,
    input  wire logic [15:0]           word_in,
    // Field values
    output var  ecp_port_cfg_t         cfg_out
);

    typedef struct packed {
        ecp_port_cfg_t cfg;
    } ecp_map_state_t;

    ecp_map_state_t s_r;
    ecp_map_state_t s_nxt;

    // Interrupt pin and bandwidth notification exist on downstream ports only.
    localparam logic DOWNSTREAM = (PORT_IDX != 0);

    always_comb
    begin
        s_nxt = s_r;
        if (ld_in[ECP_LD_W06])
        begin
            s_nxt.cfg.ext_vc_count          = word_in[W06_EXT_VC];
            s_nxt.cfg.l0s_exit_latency      = word_in[W06_L0S_LO +: 3];
            s_nxt.cfg.l1_exit_latency       = word_in[W06_L1_LO +: 3];
            s_nxt.cfg.no_order_egress       = word_in[W06_NOORD_EG];
            s_nxt.cfg.no_order_tag          = word_in[W06_NOORD_TG];
            s_nxt.cfg.store_and_forward     = word_in[W06_SNF];
            s_nxt.cfg.cut_through_threshold = word_in[W06_CT_LO +: 2];
            s_nxt.cfg.port_arbiter_mode     = word_in[W06_ARB];
            s_nxt.cfg.credit_update_mode    = word_in[W06_CRED];
            if (DOWNSTREAM)
            begin
                s_nxt.cfg.intx_pin_request = word_in[W06_INTA];
            end
        end
        if (ld_in[ECP_LD_W0C])
        begin
            s_nxt.cfg.max_payload_support          = word_in[W0C_MPS_LO +: 2];
            s_nxt.cfg.aspm_support                 = word_in[W0C_ASPM_LO +: 2];
            s_nxt.cfg.role_err_report              = word_in[W0C_RBER];
            s_nxt.cfg.msi_cap_dis                  = word_in[W0C_MSI_DIS];
            s_nxt.cfg.compliance_parity_dis        = word_in[W0C_PAR_DIS];
            s_nxt.cfg.pm_cap_dis                   = word_in[W0C_PM_DIS];
            s_nxt.cfg.posted_pass_nonposted_enable = word_in[W0C_PPNP];
            if (DOWNSTREAM)
            begin
                s_nxt.cfg.link_bw_notify_cap = word_in[W0C_LBW];
            end
            s_nxt.cfg.ordering_frozen              = word_in[W0C_FRZ];
            s_nxt.cfg.tx_frame_start_latency_mode  = word_in[W0C_SOF];
            s_nxt.cfg.surprise_down_cap            = word_in[W0C_SDN];
            s_nxt.cfg.pm_data_select_rw            = word_in[W0C_PMDS];
            s_nxt.cfg.ltr_cap_en                   = word_in[W0C_LTR];
            s_nxt.cfg.boundary_4k_check            = word_in[W0C_4KB];
        end
        if (ld_in[ECP_LD_W0E])
        begin
            s_nxt.cfg.tx_drive_level_low_deemph_margin  = word_in[W0E_LOW_LO +: 5];
            s_nxt.cfg.tx_drive_level_high_deemph_margin = word_in[W0E_HIGH_LO +: 5];
            s_nxt.cfg.tx_drive_level_half_swing_margin  = word_in[W0E_HALF_LO +: 5];
            s_nxt.cfg.obff_cap_en                       = word_in[W0E_OBFF];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_r <= '{cfg: ECP_PORT_CFG_DEFAULT};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cfg_out = s_r.cfg;

endmodule // ecp_port_map

`default_nettype wire

// [ecp_loader.sv]
// Configuration preload loader: after reset it reads word 00h and, on a signature match, words 02h to 0Eh from
// the EEPROM word engine and scatters them into the identifiers and per-port fields.
// Assumes the word engine runs on clk_sys_in and answers each request with
// a one-cycle acknowledge carrying the word.
`timescale 1ns/1ps
`default_nettype none

module ecp_loader
    import ecp_pkg::*;
#(
    parameter logic [15:0] SIGNATURE = ECP_SIG_DEFAULT
)
(
    // Clock and reset
    input  wire logic                                  clk_sys_in,
    input  wire logic                                  nrst_in,
    // EEPROM word engine
    output logic                                       rd_req_out,
    output logic [ECP_ADDR_W-1:0]                      rd_addr_out,
    input  wire logic                                  rd_ack_in,
    input  wire logic [ECP_WORD_W-1:0]                 rd_data_in,
    // Identifiers
    output ecp_ids_t                                   ids_out,
    // Per-port fields
    output ecp_port_cfg_t [ECP_NUM_PORTS-1:0]          port_cfg_out,
    // Status
    output logic                                       cfg_ready_out,
    output logic                                       image_valid_out,
    output logic                                       image_bad_out
);

    typedef struct packed {
        ecp_state_t             fsm;
        logic [ECP_ADDR_W-1:0]  addr;
        logic                   rd_req;
        logic [ECP_WORD_W-1:0]  word;
        logic                   sig_ok;
        logic                   sig_bad;
        logic                   ready;
        logic [ECP_LD_N-1:0]    ld;
        ecp_ids_t               ids;
    } ecp_ctl_state_t;

    localparam ecp_ctl_state_t CTL_RESET = '{
        fsm:     ECP_ST_IDLE,
        addr:    ECP_A_SIG,
        rd_req:  1'b0,
        word:    '0,
        sig_ok:  1'b0,
        sig_bad: 1'b0,
        ready:   1'b0,
        ld:      '0,
        ids:     ECP_IDS_DEFAULT
    };

    ecp_ctl_state_t s_r;
    ecp_ctl_state_t s_nxt;

    always_comb
    begin
        s_nxt    = s_r;
        // Load strobes last one cycle, in the cycle after the word lands.
        s_nxt.ld = '0;
        case (s_r.fsm)
            ECP_ST_IDLE:
            begin
                s_nxt.addr   = ECP_A_SIG;
                s_nxt.rd_req = 1'b1;
                s_nxt.fsm    = ECP_ST_REQ;
            end
            ECP_ST_REQ:
            begin
                // The request is held until the engine acknowledges it.
                if (rd_ack_in)
                begin
                    s_nxt.rd_req = 1'b0;
                    s_nxt.word   = rd_data_in;
                    s_nxt.fsm    = ECP_ST_WAIT;
                end
            end
            ECP_ST_WAIT:
            begin
                s_nxt.fsm = ECP_ST_NEXT;
                case (s_r.addr)
                    ECP_A_SIG:
                    begin
                        if (s_r.word == SIGNATURE)
                        begin
                            s_nxt.sig_ok = 1'b1;
                        end
                        else
                        begin
                            s_nxt.sig_bad = 1'b1;
                            s_nxt.fsm     = ECP_ST_DONE;
                        end
                    end
                    ECP_A_VID:   s_nxt.ids.vendor_id        = s_r.word;
                    ECP_A_DID:   s_nxt.ids.device_id        = s_r.word;
                    ECP_A_SSVID: s_nxt.ids.subsys_vendor_id = s_r.word;
                    ECP_A_SSID:  s_nxt.ids.subsys_id        = s_r.word;
                    // one strobe feeds every port at once
                    ECP_A_W06:   s_nxt.ld[ECP_LD_W06] = 1'b1;
                    ECP_A_W0C:   s_nxt.ld[ECP_LD_W0C] = 1'b1;
                    ECP_A_W0E:   s_nxt.ld[ECP_LD_W0E] = 1'b1;
                    default:     s_nxt.fsm = ECP_ST_DONE;
                endcase
            end
            ECP_ST_NEXT:
            begin
                if (s_r.addr == ECP_A_W0E)
                begin
                    s_nxt.fsm = ECP_ST_DONE;
                end
                else
                begin
                    s_nxt.addr   = s_r.addr + ECP_A_STEP;
                    s_nxt.rd_req = 1'b1;
                    s_nxt.fsm    = ECP_ST_REQ;
                end
            end
            ECP_ST_DONE:
            begin
                // host access only after last load
                s_nxt.ready = 1'b1;
            end
            default:
            begin
                s_nxt = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_r <= CTL_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Each port holds its own copy so a later per-port write cannot disturb
    // the others; the cost is three times the field flip-flops.
    genvar p;
    generate
        for (p = 0; p < ECP_NUM_PORTS; p++)
        begin : g_port
            ecp_port_map #(
                .PORT_IDX (p)
            ) u_map (
                .clk_sys_in (clk_sys_in),
                .nrst_in    (nrst_in),
                .ld_in      (s_r.ld),
                .word_in    (s_r.word),
                .cfg_out    (port_cfg_out[p])
            );
        end
    endgenerate

    assign rd_req_out      = s_r.rd_req;
    assign rd_addr_out     = s_r.addr;
    assign ids_out         = s_r.ids;
    assign cfg_ready_out   = s_r.ready;
    assign image_valid_out = s_r.sig_ok;
    assign image_bad_out   = s_r.sig_bad;

endmodule // ecp_loader

`default_nettype wire

// [ecp_loader_props.sv]
// Assertion checker for the preload loader, bound to every ecp_loader.
// Assumes the word engine answers on the core clock with one-cycle acks.
`timescale 1ns/1ps
`default_nettype none

module ecp_loader_props
    import ecp_pkg::*;
#(
    parameter logic [15:0] SIGNATURE = ECP_SIG_DEFAULT
)
(
    // Clock and reset
    input  wire logic                              clk_sys_in,
    input  wire logic                              nrst_in,
    // Word engine
    input  wire logic                              rd_req_out,
    input  wire logic [ECP_ADDR_W-1:0]             rd_addr_out,
    input  wire logic                              rd_ack_in,
    input  wire logic [ECP_WORD_W-1:0]             rd_data_in,
    // Results
    input  wire ecp_ids_t                          ids_out,
    input  wire ecp_port_cfg_t [ECP_NUM_PORTS-1:0] port_cfg_out,
    input  wire logic                              cfg_ready_out,
    input  wire logic                              image_valid_out,
    input  wire logic                              image_bad_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    logic       take;
    logic [7:0] next_addr_r;

    assign take = rd_req_out && rd_ack_in;

    // Address that the next request must carry; words are read strictly in order.
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            next_addr_r <= 8'h00;
        else if (take)
            next_addr_r <= rd_addr_out + ECP_A_STEP;
    end

    chk_req_hold: assert property (rd_req_out && !rd_ack_in |=> rd_req_out && $stable(rd_addr_out))
        else $error("request dropped or moved before acknowledge");
    chk_req_gap: assert property (take |=> (!rd_req_out) [*2])
        else $error("request not released after acknowledge");
    chk_addr_order: assert property (rd_req_out |-> rd_addr_out == next_addr_r)
        else $error("word address out of order");
    chk_sig_ok: assert property (take && rd_addr_out == ECP_A_SIG && rd_data_in == SIGNATURE
        |-> ##2 image_valid_out && !image_bad_out) else $error("matching signature not accepted");
    chk_sig_bad: assert property (take && rd_addr_out == ECP_A_SIG && rd_data_in != SIGNATURE
        |-> ##2 image_bad_out && !cfg_ready_out ##1 cfg_ready_out)
        else $error("bad signature not handled in time");
    chk_vid_copy: assert property (take && rd_addr_out == ECP_A_VID
        |-> ##3 ids_out.vendor_id == $past(rd_data_in, 3)) else $error("vendor word not copied");
    chk_ssid_copy: assert property (take && rd_addr_out == ECP_A_SSID
        |-> ##3 ids_out.subsys_id == $past(rd_data_in, 3)) else $error("subsystem word not copied");
    chk_margin_load: assert property (take && rd_addr_out == ECP_A_W0E
        |-> ##4 port_cfg_out[2].tx_drive_level_half_swing_margin == $past(rd_data_in[14:10], 4)
        && port_cfg_out[0].obff_cap_en == $past(rd_data_in[15], 4)) else $error("last word not applied");
    chk_ready_last: assert property (take && rd_addr_out == ECP_A_W0E
        |=> (!cfg_ready_out) [*3] ##1 cfg_ready_out) else $error("ready not three edges after last word");
    chk_port0_skip: assert property (port_cfg_out[0].intx_pin_request == 1'b0
        && port_cfg_out[0].link_bw_notify_cap == 1'b0) else $error("port 0 got a port 1-2 only field");
    chk_ports_same: assert property (cfg_ready_out && image_valid_out
        |-> port_cfg_out[1] == port_cfg_out[2]) else $error("ports 1 and 2 differ");
    chk_bad_keeps: assert property (image_bad_out
        |-> ids_out == ECP_IDS_DEFAULT && port_cfg_out == '0) else $error("defaults lost on bad image");
    chk_ready_sticky: assert property (cfg_ready_out
        |=> cfg_ready_out && !rd_req_out && (image_valid_out ^ image_bad_out)) else $error("ready state broken");
endmodule // ecp_loader_props

bind ecp_loader ecp_loader_props #(.SIGNATURE(SIGNATURE)) u_props (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out),
    .rd_ack_in(rd_ack_in), .rd_data_in(rd_data_in), .ids_out(ids_out), .port_cfg_out(port_cfg_out),
    .cfg_ready_out(cfg_ready_out), .image_valid_out(image_valid_out), .image_bad_out(image_bad_out));

`default_nettype wire

// [ecp_eeprom_model.sv]
// Behavioural word engine in front of the configuration EEPROM.
// Assumes the loader samples on the rising edge; this model moves on the falling one.
`timescale 1ns/1ps
`default_nettype none

module ecp_eeprom_model
    import ecp_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  nrst_in,
    // Behaviour chosen by the bench
    input  wire logic [7:0][15:0]      image_in,
    input  wire logic [2:0]            delay_in,
    input  wire logic                  stray_in,
    // Word engine side
    input  wire logic                  rd_req_in,
    input  wire logic [ECP_ADDR_W-1:0] rd_addr_in,
    output logic                       rd_ack_out,
    output logic [ECP_WORD_W-1:0]      rd_data_out
);
    logic [2:0] wait_cnt;

    always @(negedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_ack_out  <= 1'b0;
            rd_data_out <= 16'h0000;
            wait_cnt    <= 3'h0;
        end
        else if (!rd_ack_out && rd_req_in && wait_cnt >= delay_in)
        begin
            rd_ack_out  <= 1'b1;
            rd_data_out <= image_in[rd_addr_in[3:1]];
            wait_cnt    <= 3'h0;
        end
        else
        begin
            // Idle data keeps toggling so a late sample cannot match by luck.
            rd_ack_out  <= !rd_ack_out && !rd_req_in && stray_in;
            rd_data_out <= ~rd_data_out;
            wait_cnt    <= rd_req_in ? wait_cnt + 3'h1 : 3'h0;
        end
    end
endmodule // ecp_eeprom_model

`default_nettype wire

// [ecp_loader_tb.sv]
// Self-checking bench for the preload loader with the EEPROM word model.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ps
`default_nettype none

module ecp_loader_tb
    import ecp_pkg::*;
;
    typedef struct packed {
        ecp_ids_t                          ids;
        ecp_port_cfg_t [ECP_NUM_PORTS-1:0] ports;
        logic                              valid;
    } ecp_exp_t;

    logic                              clk_sys_in;
    logic                              nrst_in;
    logic                              rd_req_out, rd_ack_in, stray;
    logic                              cfg_ready_out, image_valid_out, image_bad_out;
    logic [7:0]                        rd_addr_out;
    logic [15:0]                       rd_data_in;
    logic [2:0]                        delay;
    logic [7:0][15:0]                  image;
    ecp_ids_t                          ids_out;
    ecp_port_cfg_t [ECP_NUM_PORTS-1:0] port_cfg_out;
    ecp_exp_t                          exp_q[$];
    int                                n_mismatch = 0;
    int                                total_checks = 0;
    int                                cycles = 0;
    logic                              seen = 1'b0;

    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    ecp_loader u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .rd_req_out(rd_req_out),
        .rd_addr_out(rd_addr_out), .rd_ack_in(rd_ack_in), .rd_data_in(rd_data_in), .ids_out(ids_out),
        .port_cfg_out(port_cfg_out), .cfg_ready_out(cfg_ready_out), .image_valid_out(image_valid_out),
        .image_bad_out(image_bad_out));

    ecp_eeprom_model u_rom (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .image_in(image), .delay_in(delay),
        .stray_in(stray), .rd_req_in(rd_req_out), .rd_addr_in(rd_addr_out), .rd_ack_out(rd_ack_in),
        .rd_data_out(rd_data_in));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_ids(input ecp_ids_t e, input ecp_ids_t g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD ids exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_port(input int p, input ecp_port_cfg_t e, input ecp_port_cfg_t g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD port%0d exp %h got %h", p, e, g);
        end
    endtask

    task automatic cmp_flag(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask

    // Fields in the declaration order of the per-port struct.
    function automatic ecp_port_cfg_t exp_port(input logic [15:0] w6, wc, we, input logic p);
        return {
            w6[0], w6[3:1], w6[6:4], wc[3:2], wc[9] & p, wc[12],
            w6[8], w6[9], w6[10], w6[12:11], w6[13], w6[14], wc[6], w6[15] & p,
            wc[1:0], wc[4], wc[5], wc[7], wc[8], wc[10], wc[11], wc[13], wc[15], wc[14],
            we[15], we[4:0], we[9:5], we[14:10]};
    endfunction

    function automatic logic [7:0][15:0] rand_img(input logic good);
        logic [7:0][15:0] w;
        for (int k = 0; k < 8; k++)
            w[k] = 16'($urandom());
        w[0] = good ? ECP_SIG_DEFAULT : ECP_SIG_DEFAULT ^ 16'h0001;
        return w;
    endfunction

    task automatic run_image(input logic [7:0][15:0] img, input logic [2:0] dly, input logic sty, input int cut);
        ecp_exp_t e;
        int       i;
        image = img;
        delay = dly;
        stray = sty;
        nrst_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        if (cut > 0)
        begin
            repeat (cut) @(negedge clk_sys_in);
            nrst_in = 1'b0;
            @(negedge clk_sys_in);
            cmp_ids(ECP_IDS_DEFAULT, ids_out);
            cmp_flag("ready", 1'b0, cfg_ready_out);
            repeat (2) @(negedge clk_sys_in);
            nrst_in = 1'b1;
        end
        e.valid = (img[0] === ECP_SIG_DEFAULT);
        e.ids = e.valid ? {img[1], img[2], img[4], img[5]} : ECP_IDS_DEFAULT;
        for (i = 0; i < 3; i++)
            e.ports[i] = e.valid ? exp_port(img[3], img[6], img[7], i != 0) : '0;
        exp_q.push_back(e);
        for (i = 0; i < 400 && cfg_ready_out !== 1'b1; i++)
            @(negedge clk_sys_in);
        cmp_flag("ready", 1'b1, cfg_ready_out);
        @(negedge clk_sys_in);
    endtask

    // Result monitor: the first ready level of each load is compared with the oldest note.
    always @(negedge clk_sys_in)
    begin
        ecp_exp_t x;
        if (!nrst_in)
            seen = 1'b0;
        else if (cfg_ready_out === 1'b1 && !seen && exp_q.size() > 0)
        begin
            seen = 1'b1;
            x = exp_q.pop_front();
            cmp_ids(x.ids, ids_out);
            for (int p = 0; p < 3; p++)
                cmp_port(p, x.ports[p], port_cfg_out[p]);
            cmp_flag("valid", x.valid, image_valid_out);
            cmp_flag("bad", !x.valid, image_bad_out);
        end
    end

    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            $display("BAD timeout exp done got running");
            stop_test();
        end
    end

    initial
    begin
        nrst_in = 1'b0;
        image = '0;
        delay = 3'h0;
        stray = 1'b0;
        void'($urandom(37));
        run_image(rand_img(1'b1), 3'h0, 1'b0, 0);
        // Boundary words; the all-ones image with the slowest engine and stray acknowledges between requests.
        run_image({{7{16'hffff}}, ECP_SIG_DEFAULT}, 3'h7, 1'b1, 0);
        run_image({{7{16'h0000}}, ECP_SIG_DEFAULT}, 3'h3, 1'b0, 0);
        for (int k = 0; k < 4; k++)
            run_image(rand_img(1'b1), 3'($urandom_range(0, 7)), 1'($urandom_range(0, 1)), 0);
        run_image(rand_img(1'b0), 3'h2, 1'b1, 0);
        run_image(rand_img(1'b1), 3'h1, 1'b0, 30);
        stop_test();
    end
endmodule // ecp_loader_tb

`default_nettype wire
